// >>> src/wst_params.svh
// Register offsets, field positions and reset values for wave-shaping timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef WST_PARAMS_SVH
`define WST_PARAMS_SVH
// Offsets are register indices; byte address is four times the index
`define WST_IDX_CLAMP_RELEASE  8'h34
`define WST_IDX_MOD_ENTRY      8'h35
`define WST_IDX_MOD_EXIT       8'h36
`define WST_IDX_CLAMP_CONNECT  8'h37
`define WST_IDX_DRIVE_RES      8'h38
`define WST_IDX_STATUS         8'h3a
`define WST_REG_RESET          8'h00
// Field low-bit positions, each field 4 bits wide
`define WST_FLD_LO             3'd0
`define WST_FLD_HI             3'd4
`define WST_FLD_W              4
`endif

// >>> src/wst_pkg.sv
// Types shared by the wave-shaping timing block.
// Assumes no surroundings beyond the design files that name it.
package wst_pkg;
  typedef enum logic [1:0] {
    WST_IDLE,
    WST_ENTRY,
    WST_HOLD,
    WST_EXIT
  } wst_state_t;
endpackage

// >>> src/wst_seq_if.sv
// Interface carrying timing fields and strobes between regs and sequencer.
// Assumes a single pclk domain on both sides.
`timescale 1ns/1ps
interface wst_seq_if;
  logic [3:0] clamp_release_time;
  logic [3:0] am_mod_start_time;
  logic [3:0] mod_resistance_time;
  logic [3:0] driver_stop_time;
  logic [3:0] rf_rail_switch_time;
  logic [3:0] clamp_connect_time;
  logic [3:0] drive_resistance_time;
  logic [6:0] strobe;
  logic       busy;
  modport regs (output clamp_release_time, am_mod_start_time, mod_resistance_time,
                output driver_stop_time, rf_rail_switch_time, clamp_connect_time,
                output drive_resistance_time, input strobe, busy);
  modport seq  (input clamp_release_time, am_mod_start_time, mod_resistance_time,
                input driver_stop_time, rf_rail_switch_time, clamp_connect_time,
                input drive_resistance_time, output strobe, busy);
endinterface

// >>> src/wst_sequencer.sv
// Carrier-period counter that fires one strobe per timing field match.
// Assumes carrier_tick and mod_pulse are on pclk, mod_pulse level high in a pulse.
`timescale 1ns/1ps
module wst_sequencer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic carrier_tick,
  input  wire logic mod_pulse,
  wst_seq_if.seq    sif
);
  wst_pkg::wst_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [6:0] strobe_reg, strobe_next;
  logic       pulse_d_reg, pulse_d_next;

  // Counts are 5 bits so a field of 15 is reached before the wrap stop
  function automatic logic hit(input logic [4:0] c, input logic [3:0] t);
    hit = (c == {1'b0, t});
  endfunction

  // Entry counts from pulse start, exit counts from pulse end
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    strobe_next  = 7'h00;
    pulse_d_next = mod_pulse;
    case (state_reg)
      wst_pkg::WST_IDLE: begin
        if (mod_pulse && !pulse_d_reg) begin
          state_next = wst_pkg::WST_ENTRY;
          cnt_next   = 5'h00;
        end
      end
      wst_pkg::WST_ENTRY: begin
        if (carrier_tick) begin
          strobe_next[0] = hit(cnt_reg, sif.clamp_release_time);
          strobe_next[1] = hit(cnt_reg, sif.am_mod_start_time);
          strobe_next[2] = hit(cnt_reg, sif.mod_resistance_time);
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'h0f) begin
            state_next = wst_pkg::WST_HOLD;
          end
        end
        if (!mod_pulse) begin
          // Short pulse: abandon remaining entry steps, begin exit
          state_next = wst_pkg::WST_EXIT;
          cnt_next   = 5'h00;
        end
      end
      wst_pkg::WST_HOLD: begin
        if (!mod_pulse) begin
          state_next = wst_pkg::WST_EXIT;
          cnt_next   = 5'h00;
        end
      end
      wst_pkg::WST_EXIT: begin
        if (carrier_tick) begin
          strobe_next[3] = hit(cnt_reg, sif.driver_stop_time);
          strobe_next[4] = hit(cnt_reg, sif.rf_rail_switch_time);
          strobe_next[5] = hit(cnt_reg, sif.clamp_connect_time);
          strobe_next[6] = hit(cnt_reg, sif.drive_resistance_time);
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'h0f) begin
            state_next = wst_pkg::WST_IDLE;
          end
        end
      end
      default: state_next = wst_pkg::WST_IDLE;
    endcase
  end

  // Registers only; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= wst_pkg::WST_IDLE;
      cnt_reg     <= 5'h00;
      strobe_reg  <= 7'h00;
      pulse_d_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      strobe_reg  <= strobe_next;
      pulse_d_reg <= pulse_d_next;
    end
  end

  assign sif.strobe = strobe_reg;
  assign sif.busy   = (state_reg != wst_pkg::WST_IDLE);
endmodule

// >>> src/wst_timing_ctrl.sv
// Wave-shaping timing control: APB register file and driver strobes.
// Assumes APB master on pclk; carrier_tick and mod_pulse synchronous to pclk.
// Summary of operation
// - clamp_release_time sits in bits 3:0 of the first timing register.
// - am_mod_start_time sits in bits 7:4 of the second timing register.
// - mod_resistance_time sits in bits 3:0 of the second timing register.
// - driver_stop_time sits in bits 7:4 of the third timing register.
// - rf_rail_switch_time sits in bits 3:0 of the third timing register.
// - clamp_connect_time sits in bits 3:0 of the fourth timing register.
// - drive_resistance_time sits in bits 7:4 of the fifth timing register.
`timescale 1ns/1ps
`include "wst_params.svh"
module wst_timing_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        carrier_tick,
  input  wire logic        mod_pulse,
  output logic             clamp_release_stb,
  output logic             am_rail_stb,
  output logic             mod_resistance_stb,
  output logic             driver_stop_stb,
  output logic             rf_rail_stb,
  output logic             clamp_connect_stb,
  output logic             drive_resistance_stb
);
  wst_seq_if sif ();

  logic [7:0]  t1_reg, t1_next;
  logic [7:0]  t2_reg, t2_next;
  logic [7:0]  t3_reg, t3_next;
  logic [7:0]  t4_reg, t4_next;
  logic [7:0]  t5_reg, t5_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        err_reg, err_next;
  logic [7:0]  idx;
  logic [5:0]  sel;
  logic        wr_acc;
  logic        wr_byte;
  logic        rd_acc;

  // Word index of the APB address
  function automatic logic [7:0] word_idx(input logic [11:0] a);
    word_idx = a[9:2];
  endfunction

  // One-hot word select shared by write, read and error decode; bit 5 is status
  function automatic logic [5:0] reg_sel(input logic [7:0] i);
    reg_sel = 6'h00;
    if (i == `WST_IDX_CLAMP_RELEASE) begin
      reg_sel = 6'h01;
    end else if (i == `WST_IDX_MOD_ENTRY) begin
      reg_sel = 6'h02;
    end else if (i == `WST_IDX_MOD_EXIT) begin
      reg_sel = 6'h04;
    end else if (i == `WST_IDX_CLAMP_CONNECT) begin
      reg_sel = 6'h08;
    end else if (i == `WST_IDX_DRIVE_RES) begin
      reg_sel = 6'h10;
    end else if (i == `WST_IDX_STATUS) begin
      reg_sel = 6'h20;
    end
  endfunction

  // Registers are one byte; upper read bits are always zero
  function automatic logic [31:0] word_of(input logic [7:0] b);
    word_of = {24'h00_0000, b};
  endfunction

  // Pick the low or high 4-bit field of a timing register
  function automatic logic [3:0] nib(input logic [7:0] r, input logic hi);
    nib = hi ? r[`WST_FLD_HI +: `WST_FLD_W] : r[`WST_FLD_LO +: `WST_FLD_W];
  endfunction

  // Bus qualifiers; everything is dead while the clock enable is low
  assign idx     = word_idx(paddr);
  assign sel     = reg_sel(idx);
  assign wr_acc  = psel && penable && pwrite && clk_en;
  assign rd_acc  = psel && penable && !pwrite && clk_en;
  assign wr_byte = wr_acc && pstrb[0];  // Only the low lane holds register bits

  // Next timing register values; reserved bits are stored as written
  always_comb begin
    t1_next = t1_reg;
    t2_next = t2_reg;
    t3_next = t3_reg;
    t4_next = t4_reg;
    t5_next = t5_reg;
    if (wr_byte) begin
      if (sel[0]) begin
        t1_next = pwdata[7:0];
      end else if (sel[1]) begin
        t2_next = pwdata[7:0];
      end else if (sel[2]) begin
        t3_next = pwdata[7:0];
      end else if (sel[3]) begin
        t4_next = pwdata[7:0];
      end else if (sel[4]) begin
        t5_next = pwdata[7:0];
      end
    end
  end

  // Timing register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_reg <= `WST_REG_RESET;
      t2_reg <= `WST_REG_RESET;
      t3_reg <= `WST_REG_RESET;
      t4_reg <= `WST_REG_RESET;
      t5_reg <= `WST_REG_RESET;
    end else if (clk_en) begin
      t1_reg <= t1_next;
      t2_reg <= t2_next;
      t3_reg <= t3_next;
      t4_reg <= t4_next;
      t5_reg <= t5_next;
    end
  end

  // Read word and error decided in setup, so the access answers at once
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (sel[0]) begin
      rdata_next = word_of(t1_reg);
    end else if (sel[1]) begin
      rdata_next = word_of(t2_reg);
    end else if (sel[2]) begin
      rdata_next = word_of(t3_reg);
    end else if (sel[3]) begin
      rdata_next = word_of(t4_reg);
    end else if (sel[4]) begin
      rdata_next = word_of(t5_reg);
    end else if (sel[5]) begin
      rdata_next = word_of({7'h00, sif.busy});  // Sequence in progress
      err_next   = pwrite;                       // Status is read-only
    end else begin
      err_next = 1'b1;  // Unmapped word
    end
  end

  // Read response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // Setup cycle latches data; access phase answers at once
  assign prdata  = (rd_acc) ? rdata_reg : 32'h0000_0000;
  assign pready  = psel && penable && clk_en;
  assign pslverr = psel && penable && clk_en && err_reg;

  // Fields to the sequencer
  assign sif.clamp_release_time    = nib(t1_reg, 1'b0);
  assign sif.am_mod_start_time     = nib(t2_reg, 1'b1);
  assign sif.mod_resistance_time   = nib(t2_reg, 1'b0);
  assign sif.driver_stop_time      = nib(t3_reg, 1'b1);
  assign sif.rf_rail_switch_time   = nib(t3_reg, 1'b0);
  assign sif.clamp_connect_time    = nib(t4_reg, 1'b0);
  assign sif.drive_resistance_time = nib(t5_reg, 1'b1);

  wst_sequencer u_seq (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .carrier_tick (carrier_tick),
    .mod_pulse    (mod_pulse),
    .sif          (sif)
  );

  // Strobes come straight from sequencer flip-flops
  assign clamp_release_stb    = sif.strobe[0];
  assign am_rail_stb          = sif.strobe[1];
  assign mod_resistance_stb   = sif.strobe[2];
  assign driver_stop_stb      = sif.strobe[3];
  assign rf_rail_stb          = sif.strobe[4];
  assign clamp_connect_stb    = sif.strobe[5];
  assign drive_resistance_stb = sif.strobe[6];
endmodule

// >>> verif/wst_timing_ctrl_checker.sv
// Checker for the wave-shaping timing block: bus answer and strobe timing.
// Assumes a single pclk domain and presetn active low.
`timescale 1ns/1ps
module wst_timing_ctrl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        carrier_tick,
  input wire logic        mod_pulse,
  input wire logic        clamp_release_stb,
  input wire logic        am_rail_stb,
  input wire logic        mod_resistance_stb,
  input wire logic        driver_stop_stb,
  input wire logic        rf_rail_stb,
  input wire logic        clamp_connect_stb,
  input wire logic        drive_resistance_stb
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Strobe groups, each must follow a carrier tick by one cycle
  sequence s_ent; clamp_release_stb || am_rail_stb || mod_resistance_stb; endsequence
  sequence s_ext; driver_stop_stb || rf_rail_stb || clamp_connect_stb || drive_resistance_stb;
  endsequence
  property p_rdy; psel && penable && clk_en |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_rdz; !(psel && penable) |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  property p_up; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("upper read bits set");
  // A frozen strobe may stand on; a freshly loaded one needs a tick before it
  property p_ent; s_ent |-> $past(carrier_tick) || !$past(clk_en); endproperty
  a_ent: assert property (p_ent) else $error("entry strobe without tick");
  property p_ext; s_ext |-> $past(carrier_tick) || !$past(clk_en); endproperty
  a_ext: assert property (p_ext) else $error("exit strobe without tick");
  property p_cr1; clamp_release_stb && clk_en |=> !clamp_release_stb; endproperty
  a_cr1: assert property (p_cr1) else $error("release strobe too long");
  property p_ds1; driver_stop_stb && clk_en |=> !driver_stop_stb; endproperty
  a_ds1: assert property (p_ds1) else $error("stop strobe too long");
  property p_mr1; mod_resistance_stb && clk_en |=> !mod_resistance_stb; endproperty
  a_mr1: assert property (p_mr1) else $error("resistance strobe too long");
endmodule
bind wst_timing_ctrl wst_timing_ctrl_checker u_chk (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .prdata, .pready, .carrier_tick, .mod_pulse, .clamp_release_stb,
  .am_rail_stb, .mod_resistance_stb, .driver_stop_stb, .rf_rail_stb, .clamp_connect_stb,
  .drive_resistance_stb);

// >>> verif/test_wave_shaping_timing_control.sv
// Self-checking bench for the wave-shaping timing block over APB.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "wst_params.svh"
module test_wave_shaping_timing_control;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, carrier_tick, mod_pulse;
  logic        pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [6:0]  stb;
  logic [7:0]  val [5] = '{8'h02, 8'h10, 8'hf0, 8'h01, 8'h20};
  int          error_cnt, check_count;
  wst_timing_ctrl u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .carrier_tick, .mod_pulse,
    .clamp_release_stb(stb[0]), .am_rail_stb(stb[1]), .mod_resistance_stb(stb[2]),
    .driver_stop_stb(stb[3]), .rf_rail_stb(stb[4]), .clamp_connect_stb(stb[5]),
    .drive_resistance_stb(stb[6]));
  // Free-running 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Byte address is four times the register index
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out;
    end
  endtask
  // One carrier period; strobes land one cycle after the tick
  task tk(input logic [6:0] e);
    @(posedge pclk) carrier_tick <= 1'b1;
    @(posedge pclk) carrier_tick <= 1'b0;
    @(negedge pclk) chk("strobes", 32'(stb), 32'(e));
  endtask
  task t_reset;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad(`WST_IDX_CLAMP_RELEASE + 8'(i)), 32'h0, 4'h0);
      chk("reset value", rd, 32'h0);
      chk("no error", 32'(er), 32'h0);
    end
  endtask
  // Clock enable drops in the access phase: ready waits, write lands once
  task t_freeze;
    fork
      apb(1'b1, ad(`WST_IDX_CLAMP_CONNECT), 32'h03, 4'hf);
      begin
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    apb(1'b0, ad(`WST_IDX_CLAMP_CONNECT), 32'h0, 4'h0);
    chk("frozen write", rd, 32'h03);
  endtask
  // Second reset in mid-run returns the registers to zero
  task t_rst2;
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ad(`WST_IDX_CLAMP_CONNECT), 32'h0, 4'h0);
    chk("reset again", rd, 32'h0);
  endtask
  task t_rw;
    for (int i = 0; i < 5; i++) apb(1'b1, ad(`WST_IDX_CLAMP_RELEASE + 8'(i)), 32'(val[i]), 4'hf);
    // Byte strobe low must leave the register alone
    apb(1'b1, ad(`WST_IDX_CLAMP_RELEASE), 32'h0f, 4'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad(`WST_IDX_CLAMP_RELEASE + 8'(i)), 32'h0, 4'h0);
      chk("read back", rd, 32'(val[i]));
    end
  endtask
  // Hole between the timing registers and the read-only status
  task t_refuse;
    apb(1'b1, ad(8'h39), 32'h5, 4'hf);
    chk("unmapped error", 32'(er), 32'h1);
    apb(1'b1, ad(`WST_IDX_STATUS), 32'h1, 4'hf);
    chk("status write error", 32'(er), 32'h1);
  endtask
  task t_seq;
    @(posedge pclk) mod_pulse <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 4; k++) tk({4'h0, k == 0, k == 1, k == 2});
    apb(1'b0, ad(`WST_IDX_STATUS), 32'h0, 4'h0);
    chk("busy", rd, 32'h1);
    @(posedge pclk) mod_pulse <= 1'b0;
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 16; k++) tk({k == 2, k == 1, k == 0, k == 15, 3'h0});
    repeat (4) @(posedge pclk);
    apb(1'b0, ad(`WST_IDX_STATUS), 32'h0, 4'h0);
    chk("idle", rd, 32'h0);
  endtask
  // Main sequence: reset held five cycles, then scenarios
  initial begin
    presetn      = 1'b0;
    clk_en       = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h0;
    pwdata       = 32'h0;
    pstrb        = 4'h0;
    carrier_tick = 1'b0;
    mod_pulse    = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rw;
    t_refuse;
    t_seq;
    t_freeze;
    t_rst2;
    close_out;
  end
endmodule
